// *** logic/led_pwm_brightness_ctrl.sv ***
// sixteen-channel led pwm brightness generator with serial register input
// assumes select_low, serial_clk, serial_data and addr_pins come from
// outside the ref_clk domain; the link clock is sampled, never used as clock

`timescale 1ns/1ps

module led_pwm_brightness_ctrl (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic select_low,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic [5:0] addr_pins,
    output logic [15:0] sink_outputs,
    output logic [15:0] sink_oe_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sel_sync;
        logic [1:0] clk_sync;
        logic [1:0] dat_sync;
        logic sel_prev;
        logic clk_prev;
        logic [5:0] addr_s1;
        logic [5:0] addr_s2;
        led_pwm_pkg::rx_state_t rx;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] reg_idx;
        logic pend;
        logic [7:0] pend_byte;
        logic [7:0] pend_idx;
        logic [7:0] ctrl;
        logic [15:0][7:0] bright;
        logic [1:0] div;
        logic [7:0] pwm_cnt;
        logic [15:0] sink;
    } state_t;

    state_t q;
    state_t next_q;
    logic [15:0] on_vec;
    logic sel_fall;
    logic sel_rise;
    logic clk_rise;
    logic byte_done;
    logic [7:0] new_byte;
    logic addr_match;
    logic do_write;
    logic [7:0] wbyte;
    logic [7:0] widx;
    logic [3:0] wch;

    // ----------------------------------------------------------------
    // per-channel pwm compare
    // ----------------------------------------------------------------
    // the global window uses the low six bits of the phase-shifted count,
    // so each 64-tick quarter passes (global+1) ticks of the duty window
    for (genvar ch = 0; ch < led_pwm_pkg::CHANNELS; ch++) begin : g_chan
        localparam logic [7:0] OFF_N = 8'(ch * led_pwm_pkg::NORMAL_STEP);
        localparam logic [7:0] OFF_G =
            8'(led_pwm_pkg::phase_group(ch) * led_pwm_pkg::GROUP_STEP);
        logic [7:0] pos;
        assign pos = q.pwm_cnt -
            (q.ctrl[led_pwm_pkg::PHASE_BIT] ? OFF_G : OFF_N);
        assign on_vec[ch] = (pos < q.bright[ch]) &&
            (pos[5:0] <= q.ctrl[led_pwm_pkg::GLOBAL_MSB:0]);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.sel_sync = {q.sel_sync[0], select_low};
        next_q.clk_sync = {q.clk_sync[0], serial_clk};
        next_q.dat_sync = {q.dat_sync[0], serial_data};
        next_q.sel_prev = q.sel_sync[1];
        next_q.clk_prev = q.clk_sync[1];
        next_q.addr_s1 = addr_pins;
        next_q.addr_s2 = q.addr_s1;

        sel_fall = q.sel_prev && !q.sel_sync[1];
        sel_rise = !q.sel_prev && q.sel_sync[1];
        clk_rise = !q.clk_prev && q.clk_sync[1] && !q.sel_sync[1];
        new_byte = {q.shift[6:0], q.dat_sync[1]};
        byte_done = clk_rise && (q.bit_cnt == 3'h7) &&
            (q.rx != led_pwm_pkg::RX_IDLE) && (q.rx != led_pwm_pkg::RX_SKIP);
        addr_match = (new_byte[7:6] == 2'h0) &&
            (q.addr_s2 != led_pwm_pkg::NO_WRITE_ADDR) &&
            ((new_byte[5:0] == q.addr_s2) ||
             (new_byte == led_pwm_pkg::BROADCAST_ADDR));
        do_write = 1'b0;
        wbyte = q.pend_byte;
        widx = q.pend_idx;

        // a select pulse always restarts the frame, so a short low pulse
        // also serves as the receiver's initialisation
        if (sel_rise) begin
            do_write = q.pend;
            next_q.pend = 1'b0;
            next_q.rx = led_pwm_pkg::RX_IDLE;
        end else if (sel_fall) begin
            next_q.pend = 1'b0;
            next_q.bit_cnt = 3'h0;
            next_q.rx = led_pwm_pkg::RX_ADDR;
        end else if (clk_rise) begin
            next_q.shift = new_byte;
            next_q.bit_cnt = 3'(q.bit_cnt + 3'h1);
            if (byte_done) begin
                case (q.rx)
                    led_pwm_pkg::RX_ADDR: begin
                        next_q.rx = addr_match ? led_pwm_pkg::RX_REG
                                               : led_pwm_pkg::RX_SKIP;
                    end
                    led_pwm_pkg::RX_REG: begin
                        next_q.reg_idx = new_byte;
                        next_q.rx = led_pwm_pkg::RX_DATA;
                    end
                    led_pwm_pkg::RX_DATA: begin
                        // held until the next byte or select release
                        do_write = q.pend;
                        next_q.pend = 1'b1;
                        next_q.pend_byte = new_byte;
                        next_q.pend_idx = q.reg_idx;
                        next_q.reg_idx = 8'(q.reg_idx + 8'h01);
                    end
                    default: begin
                        next_q.rx = led_pwm_pkg::RX_SKIP;
                    end
                endcase
            end
        end

        wch = 4'(widx - led_pwm_pkg::BRIGHT_BASE);
        if (do_write) begin
            if (widx == led_pwm_pkg::CTRL_INDEX) begin
                next_q.ctrl = wbyte;
            end else if (widx < led_pwm_pkg::REG_COUNT) begin
                next_q.bright[wch] = wbyte;
            end
        end

        next_q.div = (q.div == led_pwm_pkg::TICK_LAST) ? 2'h0
                                                        : 2'(q.div + 2'h1);
        if (q.div == led_pwm_pkg::TICK_LAST) begin
            next_q.pwm_cnt = 8'(q.pwm_cnt + 8'h01);
        end
        next_q.sink = q.ctrl[led_pwm_pkg::ENABLE_BIT] ? on_vec : 16'h0000;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.sel_sync <= 2'h3;
            q.sel_prev <= 1'b1;
            q.rx <= led_pwm_pkg::RX_IDLE;
            q.ctrl <= led_pwm_pkg::CTRL_RESET;
            q.bright <= {16{led_pwm_pkg::BRIGHT_RESET}};
        end else begin
            q <= next_q;
        end
    end

    // disabled outputs float rather than sink
    assign sink_outputs = q.sink;
    assign sink_oe_n = q.ctrl[led_pwm_pkg::ENABLE_BIT] ? 16'h0000
                                                       : 16'hffff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_zero_off;
        q.bright[3] == 8'h00 |=> !q.sink[3];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero duty lit");

    // enable comes from ctrl at once, the sinks follow one cycle later;
    // a write that sets enable must not count as a disabled cycle
    property p_disable;
        !q.ctrl[led_pwm_pkg::ENABLE_BIT] |->
            (sink_oe_n == 16'hffff) ##1 (q.sink == 16'h0000);
    endproperty
    a_disable: assert property (p_disable) else $error("disabled lit");

    property p_wrap;
        (q.div == 2'h3 && q.pwm_cnt == 8'hff) |=> q.pwm_cnt == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("bad period");

    property p_on_frac;
        (q.ctrl == 8'h7f && q.pwm_cnt < q.bright[0]) |=> q.sink[0];
    endproperty
    a_on_frac: assert property (p_on_frac) else $error("duty short");

    property p_normal_shift;
        (q.ctrl == 8'h7f && q.pwm_cnt == 8'h10 && q.bright[1] != 8'h00)
            |=> q.sink[1];
    endproperty
    a_normal_shift: assert property (p_normal_shift)
        else $error("phase start wrong");

    property p_group_share;
        (q.ctrl[7:6] == 2'h3 && q.bright[0] == q.bright[2])
            |=> q.sink[0] == q.sink[2];
    endproperty
    a_group_share: assert property (p_group_share)
        else $error("group split");

    property p_global_mask;
        (q.ctrl[7] == 1'b0 && q.pwm_cnt[5:0] > q.ctrl[5:0]) |=> !q.sink[0];
    endproperty
    a_global_mask: assert property (p_global_mask)
        else $error("global not masking");

    property p_bad_addr;
        (q.rx == led_pwm_pkg::RX_ADDR && byte_done && new_byte[7:6] != 2'h0)
            |=> q.rx == led_pwm_pkg::RX_SKIP;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("address accepted");

    property p_advance;
        (q.rx == led_pwm_pkg::RX_DATA && byte_done && !sel_rise)
            |=> q.reg_idx == 8'($past(q.reg_idx) + 8'h01);
    endproperty
    a_advance: assert property (p_advance)
        else $error("index stuck");

    property p_restart;
        sel_fall |=> (q.rx == led_pwm_pkg::RX_ADDR) && (q.bit_cnt == 3'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

endmodule : led_pwm_brightness_ctrl

// *** pkg/led_pwm_pkg.sv ***
// constants and shared helpers for the sixteen-channel led pwm block
// assumes a 20 MHz reference clock and a write-only serial register link

package led_pwm_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int CHANNELS = 16;
    localparam logic [7:0] CTRL_INDEX = 8'h00;
    localparam logic [7:0] BRIGHT_BASE = 8'h01;
    localparam logic [7:0] REG_COUNT = 8'h11;
    localparam int GLOBAL_MSB = 5;
    localparam int ENABLE_BIT = 6;
    localparam int PHASE_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BRIGHT_RESET = 8'h00;

    // ----------------------------------------------------------------
    // addressing
    // ----------------------------------------------------------------
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    localparam logic [5:0] NO_WRITE_ADDR = 6'h3f;

    // ----------------------------------------------------------------
    // pwm timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_HZ = 5_000_000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
    localparam int NORMAL_STEP = 16;
    localparam int GROUP_STEP = 42;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_ADDR,
        RX_REG,
        RX_DATA,
        RX_SKIP
    } rx_state_t;

    // channel to phase group: 0-2, 3-5, 6-7, 8-9, 10-12, 13-15
    function automatic int phase_group(input int ch);
        int g;
        g = 5;
        if (ch < 3) g = 0;
        else if (ch < 6) g = 1;
        else if (ch < 8) g = 2;
        else if (ch < 10) g = 3;
        else if (ch < 13) g = 4;
        return g;
    endfunction : phase_group

endpackage : led_pwm_pkg

// *** bench/host_link_model.sv ***
// host side of the write-only serial register link
// assumes the caller sits in the ref_clk domain; link levels last 4 cycles

`timescale 1ns/1ps

module host_link_model (
    input wire logic ref_clk,
    output logic select_low,
    output logic serial_clk,
    output logic serial_data
);
    // ----------------------------------------------------------------
    // link idle: clock parked low, data left at the inverse of the last bit
    // ----------------------------------------------------------------
    initial begin
        select_low = 1'b1;
        serial_clk = 1'b0;
        serial_data = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : hold

    // select pulse of 8 cycles, twice the shortest allowed
    task automatic init_pulse();
        select_low <= 1'b0;
        hold(8);
        select_low <= 1'b1;
        hold(4);
    endtask : init_pulse

    task automatic send_frame(input logic [7:0] bytes[$]);
        select_low <= 1'b0;
        hold(4);
        foreach (bytes[k]) begin
            for (int i = 7; i >= 0; i--) begin
                serial_data <= bytes[k][i];
                hold(4);
                serial_clk <= 1'b1;
                hold(4);
                serial_clk <= 1'b0;
            end
        end
        hold(4);
        select_low <= 1'b1;
        serial_data <= ~serial_data;
        hold(4);
    endtask : send_frame
endmodule : host_link_model

// *** bench/testbench.sv ***
// self-checking bench for the led pwm block, driven by the host model
// assumes one pwm period is 1024 ref_clk cycles at 20 MHz

`timescale 1ns/1ps

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    failures++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end end

module testbench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] addr_pins = 6'h05;
    logic select_low, serial_clk, serial_data;
    logic [15:0] sink_outputs, sink_oe_n;
    logic [7:0] q[$];
    int failures = 0;
    int checks_done = 0;
    int on_cnt[16];
    int ovl, grp_bad;
    int lead[16] = '{0, 0, 0, 3, 3, 3, 6, 6, 8, 8, 10, 10, 10, 13, 13, 13};

    always #25 ref_clk = ~ref_clk;

    host_link_model host (.ref_clk(ref_clk), .select_low(select_low),
        .serial_clk(serial_clk), .serial_data(serial_data));
    led_pwm_brightness_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .select_low(select_low), .serial_clk(serial_clk),
        .serial_data(serial_data), .addr_pins(addr_pins),
        .sink_outputs(sink_outputs), .sink_oe_n(sink_oe_n));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // on cycles per period: 4 ref_clk per tick, global window of g+1 ticks
    function automatic int expect_on(input int b, input int g);
        int n;
        n = 0;
        for (int p = 0; p < 256; p++) if (p < b && p % 64 <= g) n += 4;
        return n;
    endfunction : expect_on

    task automatic test_done();
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic measure();
        foreach (on_cnt[c]) on_cnt[c] = 0;
        ovl = 0;
        grp_bad = 0;
        repeat (1024) begin
            @(negedge ref_clk);
            for (int c = 0; c < 16; c++) begin
                on_cnt[c] += int'(sink_outputs[c] === 1'b1);
                grp_bad += int'(sink_outputs[c] !== sink_outputs[lead[c]]);
            end
            if ($countones(sink_outputs) > 1) ovl++;
        end
    endtask : measure

    task automatic frame_all(input logic [7:0] ctl, input logic [7:0] b[16]);
        q = '{8'h05, 8'h00, ctl};
        foreach (b[c]) q.push_back(b[c]);
        host.send_frame(q);
        repeat (8) @(posedge ref_clk);
    endtask : frame_all

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] b[16];
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("oe_n reset", 16'hffff, sink_oe_n)
        `CHK("sink reset", 16'h0000, sink_outputs)
        repeat (3) @(posedge ref_clk);
        host.init_pulse();
        host.send_frame('{8'hff});
        foreach (b[c]) b[c] = 8'(c * 17);
        frame_all(8'h7f, b);
        `CHK("oe_n on", 16'h0000, sink_oe_n)
        measure();
        for (int c = 0; c < 16; c++)
            `CHK("on time", expect_on(c * 17, 63), on_cnt[c])
        // broadcast, global step 15 replaces 63 at once
        host.send_frame('{8'h00, 8'h00, 8'h4f});
        repeat (8) @(posedge ref_clk);
        measure();
        `CHK("global 255", expect_on(255, 15), on_cnt[15])
        `CHK("global 136", expect_on(136, 15), on_cnt[8])
        // 16-tick pulses on 16-tick steps never overlap when all differ
        foreach (b[c]) b[c] = 8'h10;
        frame_all(8'h7f, b);
        measure();
        `CHK("normal overlap", 0, ovl)
        `CHK("normal on", 64, on_cnt[5])
        host.send_frame('{8'h05, 8'h00, 8'hff});
        repeat (8) @(posedge ref_clk);
        measure();
        `CHK("group match", 0, grp_bad)
        `CHK("group overlap", 384, ovl)
        // upper address bits set, then a foreign address: both ignored
        host.send_frame('{8'h45, 8'h00, 8'h00});
        host.send_frame('{8'h06, 8'h00, 8'h00});
        repeat (8) @(posedge ref_clk);
        `CHK("oe_n kept", 16'h0000, sink_oe_n)
        // straps all high: even a broadcast must not land
        addr_pins <= 6'h3f;
        repeat (4) @(posedge ref_clk);
        host.send_frame('{8'h00, 8'h00, 8'h00});
        repeat (8) @(posedge ref_clk);
        `CHK("oe_n strap", 16'h0000, sink_oe_n)
        addr_pins <= 6'h05;
        repeat (4) @(posedge ref_clk);
        host.send_frame('{8'h05, 8'h00, 8'h3f});
        repeat (8) @(posedge ref_clk);
        measure();
        `CHK("oe_n off", 16'hffff, sink_oe_n)
        `CHK("off on time", 0, on_cnt[5])
        test_done();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        test_done();
    end
endmodule : testbench
